// file: verilog/predriver_diag_pkg.sv
// Constants, register map and reset values for the driver fault diagnostics
package predriver_diag_pkg;

    // Channel layout: low-side drivers first, then pre-drivers
    localparam int NUM_LSD = 6;
    localparam int NUM_PRE = 3;
    localparam int NUM_CH = NUM_LSD + NUM_PRE;
    localparam int PRE_HEATER = 0;
    localparam int PRE_IGN_ONE = 1;
    localparam int PRE_IGN_TWO = 2;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_FIRST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_LAST = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_SPI_ON = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h11;
    localparam logic [ADDR_W-1:0] ADDR_GATE_MODE = 8'h12;
    localparam logic [ADDR_W-1:0] ADDR_OUT_STATE = 8'h13;

    // Status register fields
    localparam int ST_ANY_BIT = 7;
    localparam int ST_OL_BIT = 3;
    localparam int ST_OC_BIT = 2;
    localparam int ST_SHUT_BIT = 1;
    localparam int ST_ON_BIT = 0;

    // Configuration register fields
    localparam int CFG_RETRY_BIT = 0;
    localparam int CFG_SINK_BIT = 1;

    // Reset values
    localparam logic [NUM_CH-1:0] SPI_ON_RST = 9'h000;
    localparam logic RETRY_EN_RST = 1'b0;
    localparam logic SINK_EN_RST = 1'b1;
    localparam logic [NUM_PRE-1:0] GATE_MODE_RST = 3'h0;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_TIME_NS = 2000;
    localparam int RETRY_TIME_NS = 10000;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] BLANK_CYCLES =
        CNT_W'((BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RETRY_CYCLES =
        CNT_W'((RETRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// file: verilog/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// file: verilog/predriver_fault_diagnostics.sv
// Overcurrent diagnostics for pre-drivers, open-load diagnostics for low-side drivers and pre-drivers
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

// What this block does
// R1 - Feedback comparator trip while on flags overcurrent
// R2 - Sense over threshold sets flag, turns off
// R3 - Both ignition transistor mode on: 400 mV
// R4 - Flag clears only by zero write, fault gone
// R5 - No retry: restart needs fault gone, off-on
// R6 - Retry enabled: device keeps retrying switch-on
// R7 - Open load judged only in off state
// R8 - Sink config bit enables pull-down source
// R9 - Low-side open load from 2.5 V comparator
// R10 - Pre-driver open load: feedback, mode threshold
// R11 - Open-load flag latched from comparator output
// R12 - Flags and shutdown independent per channel
module predriver_fault_diagnostics
    import predriver_diag_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [NUM_CH-1:0] direct_on,
    input wire logic [NUM_LSD-1:0] lsd_out_high,
    input wire logic [NUM_PRE-1:0] feedback_pin_high,
    input wire logic [NUM_PRE-1:0] sense_over,
    output logic [NUM_CH-1:0] gate_on,
    output logic ol_sink_en,
    output logic [NUM_PRE-1:0] feedback_low_thresh_sel,
    output logic ignition_sense_thresh_high
);

    typedef struct packed {
        logic [NUM_CH-1:0] gate;
        logic [NUM_CH-1:0] shut;
        logic [NUM_CH-1:0] oc_flag;
        logic [NUM_CH-1:0] ol_flag;
        logic [NUM_CH-1:0] seen_off;
        logic [NUM_CH-1:0][CNT_W-1:0] cnt;
        logic [NUM_CH-1:0] spi_on;
        logic retry_en;
        logic sink_en;
        logic [NUM_PRE-1:0] gate_mode;
        logic sense_high;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [NUM_CH-1:0] direct_on_s;
    logic [NUM_LSD-1:0] lsd_out_high_s;
    logic [NUM_PRE-1:0] feedback_high_s;
    logic [NUM_PRE-1:0] sense_over_s;

    pin_sync #(.WIDTH(NUM_CH)) u_sync_on (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(direct_on),
        .sync_out(direct_on_s)
    );

    pin_sync #(.WIDTH(NUM_LSD)) u_sync_lsd (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(lsd_out_high),
        .sync_out(lsd_out_high_s)
    );

    pin_sync #(.WIDTH(NUM_PRE)) u_sync_fb (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(feedback_pin_high),
        .sync_out(feedback_high_s)
    );

    pin_sync #(.WIDTH(NUM_PRE)) u_sync_sense (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(sense_over),
        .sync_out(sense_over_s)
    );

    // Status word of one channel
    function automatic logic [DATA_W-1:0] status_word(
        input logic oc,
        input logic ol,
        input logic shut,
        input logic on
    );
        logic [DATA_W-1:0] w;
        w = '0;
        w[ST_ANY_BIT] = oc | ol;
        w[ST_OL_BIT] = ol;
        w[ST_OC_BIT] = oc;
        w[ST_SHUT_BIT] = shut;
        w[ST_ON_BIT] = on;
        return w;
    endfunction

    // Channel index of a status address
    function automatic logic [ADDR_W-1:0] status_index(input logic [ADDR_W-1:0] a);
        return ADDR_W'(a - ADDR_STATUS_FIRST);
    endfunction

    function automatic logic is_status(input logic [ADDR_W-1:0] a);
        return (a >= ADDR_STATUS_FIRST) && (a <= ADDR_STATUS_LAST);
    endfunction

    logic [NUM_CH-1:0] cmd_on;
    logic [NUM_CH-1:0] oc_now;
    logic [NUM_CH-1:0] ol_now;
    logic [NUM_CH-1:0] settled;
    logic [NUM_CH-1:0] clr_oc;
    logic [NUM_CH-1:0] clr_ol;

    always_comb begin
        st_nxt = st_r;
        cmd_on = direct_on_s | st_r.spi_on;
        oc_now = '0;
        ol_now = '0;
        settled = '0;
        clr_oc = '0;
        clr_ol = '0;

        // Register writes
        if (reg_wr) begin
            if (is_status(reg_addr)) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (status_index(reg_addr) == ADDR_W'(i)) begin
                        clr_oc[i] = ~reg_wdata[ST_OC_BIT];
                        clr_ol[i] = ~reg_wdata[ST_OL_BIT];
                    end
                end
            end else if (reg_addr == ADDR_SPI_ON) begin
                st_nxt.spi_on = reg_wdata[NUM_CH-1:0];
            end else if (reg_addr == ADDR_CONFIG) begin
                st_nxt.retry_en = reg_wdata[CFG_RETRY_BIT];
                st_nxt.sink_en = reg_wdata[CFG_SINK_BIT]; // R8
            end else if (reg_addr == ADDR_GATE_MODE) begin
                st_nxt.gate_mode = reg_wdata[NUM_PRE-1:0];
            end
        end

        // Fault detection per channel
        for (int i = 0; i < NUM_CH; i++) begin
            settled[i] = (st_r.cnt[i] >= BLANK_CYCLES);
            if (i >= NUM_LSD) begin
                // Feedback comparator threshold follows gate mode
                oc_now[i] = st_r.gate[i] & settled[i]
                    & (feedback_high_s[i-NUM_LSD] | sense_over_s[i-NUM_LSD]); // R1 R2
                ol_now[i] = ~st_r.gate[i] & ~st_r.shut[i] & st_r.sink_en & settled[i]
                    & ~feedback_high_s[i-NUM_LSD]; // R7 R10
            end else begin
                ol_now[i] = ~st_r.gate[i] & ~st_r.shut[i] & st_r.sink_en & settled[i]
                    & ~lsd_out_high_s[i]; // R7 R9
            end
        end

        // Flags and shutdown, each channel on its own
        for (int i = 0; i < NUM_CH; i++) begin
            // Set wins over a clearing write
            if (oc_now[i]) begin
                st_nxt.oc_flag[i] = 1'b1; // R2 R12
            end else if (clr_oc[i]) begin
                st_nxt.oc_flag[i] = 1'b0; // R4
            end
            if (ol_now[i]) begin
                st_nxt.ol_flag[i] = 1'b1; // R11 R12
            end else if (clr_ol[i]) begin
                st_nxt.ol_flag[i] = 1'b0; // R4
            end

            if (oc_now[i]) begin
                st_nxt.shut[i] = 1'b1; // R2
                st_nxt.seen_off[i] = 1'b0;
            end else if (st_r.shut[i]) begin
                if (st_r.retry_en) begin
                    if (st_r.cnt[i] >= RETRY_CYCLES) begin
                        st_nxt.shut[i] = 1'b0; // R6
                    end
                end else if (!cmd_on[i]) begin
                    st_nxt.seen_off[i] = 1'b1; // R5
                end else if (st_r.seen_off[i]) begin
                    st_nxt.shut[i] = 1'b0; // R5
                end
            end

            st_nxt.gate[i] = cmd_on[i] & ~st_nxt.shut[i];

            // Time since last gate change or since shutdown
            if (st_nxt.gate[i] != st_r.gate[i]) begin
                st_nxt.cnt[i] = '0;
            end else if (st_r.cnt[i] != {CNT_W{1'b1}}) begin
                st_nxt.cnt[i] = st_r.cnt[i] + CNT_W'(1);
            end
        end

        // Raised sense threshold for both ignition outputs
        st_nxt.sense_high = st_nxt.gate_mode[PRE_IGN_ONE] & st_nxt.gate_mode[PRE_IGN_TWO]
            & st_nxt.gate[NUM_LSD+PRE_IGN_ONE] & st_nxt.gate[NUM_LSD+PRE_IGN_TWO]; // R3

        // Register reads, data in the next cycle only
        st_nxt.rdata = '0;
        if (reg_rd) begin
            if (is_status(reg_addr)) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (status_index(reg_addr) == ADDR_W'(i)) begin
                        st_nxt.rdata = status_word(st_r.oc_flag[i], st_r.ol_flag[i],
                            st_r.shut[i], st_r.gate[i]);
                    end
                end
            end else if (reg_addr == ADDR_SPI_ON) begin
                st_nxt.rdata = DATA_W'(st_r.spi_on);
            end else if (reg_addr == ADDR_CONFIG) begin
                st_nxt.rdata[CFG_RETRY_BIT] = st_r.retry_en;
                st_nxt.rdata[CFG_SINK_BIT] = st_r.sink_en;
            end else if (reg_addr == ADDR_GATE_MODE) begin
                st_nxt.rdata = DATA_W'(st_r.gate_mode);
            end else if (reg_addr == ADDR_OUT_STATE) begin
                st_nxt.rdata = DATA_W'(st_r.gate);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.gate <= '0;
            st_r.shut <= '0;
            st_r.oc_flag <= '0;
            st_r.ol_flag <= '0;
            st_r.seen_off <= '0;
            st_r.cnt <= '0;
            st_r.spi_on <= SPI_ON_RST;
            st_r.retry_en <= RETRY_EN_RST;
            st_r.sink_en <= SINK_EN_RST;
            st_r.gate_mode <= GATE_MODE_RST;
            st_r.sense_high <= 1'b0;
            st_r.rdata <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign gate_on = st_r.gate;
    assign ol_sink_en = st_r.sink_en; // R8
    assign feedback_low_thresh_sel = st_r.gate_mode; // R1 R10
    assign ignition_sense_thresh_high = st_r.sense_high; // R3
    assign reg_rdata = st_r.rdata;

endmodule

// file: bench/predriver_fault_monitor.sv
// Port checker for the fault diagnostics block
`timescale 1ns/1ps
module predriver_fault_monitor
    import predriver_diag_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [NUM_PRE-1:0] feedback_pin_high,
    input wire logic [NUM_PRE-1:0] sense_over,
    input wire logic [NUM_CH-1:0] gate_on,
    input wire logic ol_sink_en,
    input wire logic [NUM_PRE-1:0] feedback_low_thresh_sel,
    input wire logic ignition_sense_thresh_high
);
    logic [7:0] on6_r;
    logic sink_r;
    logic [2:0] mode_r;
    logic cfg_w;
    logic gm_w;
    logic ign_w;
    assign cfg_w = reg_wr && reg_addr == ADDR_CONFIG;
    assign gm_w = reg_wr && reg_addr == ADDR_GATE_MODE;
    assign ign_w = &mode_r[2:1] && &gate_on[8:7];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            on6_r <= 8'h00;
            sink_r <= SINK_EN_RST;
            mode_r <= GATE_MODE_RST;
        end else begin
            on6_r <= gate_on[6] ? on6_r + {7'h00, on6_r != 8'hFF} : 8'h00;
            sink_r <= cfg_w ? reg_wdata[CFG_SINK_BIT] : sink_r;
            mode_r <= gm_w ? reg_wdata[2:0] : mode_r;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Trip held through the sync depth, past blanking
    sequence hit(s);
        (on6_r > 8'd205 && s) [*3];
    endsequence
    AST_OC_SENSE: assert property (hit(sense_over[0]) |-> ##[1:2] !gate_on[6])
        else $error("gate on after sense trip");
    AST_OC_FB: assert property (hit(feedback_pin_high[0]) |-> ##[1:2] !gate_on[6])
        else $error("gate on after feedback trip");
    AST_THRESH: assert property (ignition_sense_thresh_high == ign_w)
        else $error("sense threshold select wrong");
    AST_SINK: assert property (cfg_w |=> ##[0:1] ol_sink_en == sink_r)
        else $error("sink enable not updated");
    AST_MODE: assert property (gm_w |=> ##[0:1] feedback_low_thresh_sel == mode_r)
        else $error("feedback threshold select wrong");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside slot");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > ADDR_OUT_STATE |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_RST: assert property ($rose(reset_n) |-> gate_on == 9'h000 && ol_sink_en)
        else $error("bad state after reset");
endmodule
bind predriver_fault_diagnostics predriver_fault_monitor u_predriver_fault_monitor (.*);

// file: bench/load_model.sv
// Loads, sense resistors and comparators on the driver outputs
`timescale 1ns/1ps
module load_model
    import predriver_diag_pkg::*;
(
    input wire logic clk,
    input wire logic [NUM_CH-1:0] gate_on,
    input wire logic ol_sink_en,
    input wire logic [NUM_CH-1:0] open_ld,
    input wire logic [NUM_CH-1:0] short_ld,
    input wire logic [NUM_PRE-1:0] over_ld,
    output logic [NUM_LSD-1:0] lsd_out_high,
    output logic [NUM_PRE-1:0] feedback_pin_high,
    output logic [NUM_PRE-1:0] sense_over
);
    logic flip_r = 1'b0;
    logic [NUM_CH-1:0] lvl;
    always @(posedge clk) flip_r <= ~flip_r;
    // Off: load pulls high, open pin sinks low or floats
    always_comb
        for (int i = 0; i < NUM_CH; i++)
            lvl[i] = gate_on[i] ? short_ld[i] : !open_ld[i] || (!ol_sink_en && flip_r);
    assign {feedback_pin_high, lsd_out_high} = lvl;
    assign sense_over = over_ld & gate_on[NUM_CH-1:NUM_LSD];
endmodule

// file: bench/test_predriver_fault_diagnostics.sv
// Self-checking bench for the driver fault diagnostics
`timescale 1ns/1ps
module test_predriver_fault_diagnostics;
    import predriver_diag_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
    logic ol_sink_en, ignition_sense_thresh_high;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 16'h0000, reg_rdata, expq[$];
    logic [NUM_CH-1:0] direct_on = 9'h000, open_ld = 9'h000, short_ld = 9'h000, gate_on;
    logic [NUM_LSD-1:0] lsd_out_high;
    logic [NUM_PRE-1:0] over_ld = 3'h0, feedback_pin_high, sense_over, feedback_low_thresh_sel;
    logic [31:0] seed = 32'hBE8D;
    int miscompares = 0, checks_done = 0;
    always #5 clk = ~clk;
    predriver_fault_diagnostics u_predriver_fault_diagnostics (.*);
    load_model u_load_model (.*);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Write, or read with the expected word in d
    task automatic bus(input bit w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        if (!w) expq.push_back(d);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic wait_gate(input int ch, input int lim);
        int n = 0;
        while (gate_on[ch] !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (gate_on[ch] !== 1'b1) begin
            miscompares++;
            $display("Error %0t: gate %0d stayed off", $time, ch);
            final_report();
        end
    endtask
    always @(posedge clk) begin
        if (rd_seen) cmp(reg_rdata, expq.pop_front());
        rd_seen <= reg_rd;
    end
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        seed = xs(seed);
        bus(0, ADDR_CONFIG, 16'h0002);
        bus(1, {3'h1, seed[4:0]}, seed[15:0]);
        bus(0, {3'h1, seed[4:0]}, 16'h0000);
        open_ld <= 9'h041;
        repeat (230) @(posedge clk);
        bus(0, 8'h00, 16'h0088);
        bus(0, 8'h01, 16'h0000);
        bus(0, 8'h06, 16'h0088);
        bus(1, 8'h06, 16'h0000);
        bus(0, 8'h06, 16'h0088);
        open_ld <= 9'h000;
        repeat (5) @(posedge clk);
        bus(1, 8'h00, 16'h0000);
        bus(1, 8'h06, 16'h0000);
        bus(0, 8'h06, 16'h0000);
        bus(1, ADDR_CONFIG, 16'h0000);
        open_ld <= 9'h002;
        repeat (230) @(posedge clk);
        bus(0, 8'h01, 16'h0000);
        bus(0, ADDR_CONFIG, 16'h0000);
        open_ld <= 9'h000;
        repeat (5) @(posedge clk);
        bus(1, ADDR_CONFIG, 16'h0002);
        bus(1, ADDR_SPI_ON, 16'h0040);
        repeat (230) @(posedge clk);
        over_ld <= 3'h1;
        repeat (10) @(posedge clk);
        bus(0, 8'h06, 16'h0086);
        bus(0, 8'h07, 16'h0000);
        over_ld <= 3'h0;
        repeat (20) @(posedge clk);
        bus(0, ADDR_OUT_STATE, 16'h0000);
        bus(1, ADDR_SPI_ON, 16'h0000);
        bus(1, ADDR_SPI_ON, 16'h0040);
        wait_gate(6, 5);
        bus(1, 8'h06, 16'h0000);
        bus(0, 8'h06, 16'h0001);
        bus(1, ADDR_CONFIG, 16'h0003);
        repeat (230) @(posedge clk);
        short_ld <= 9'h040;
        repeat (10) @(posedge clk);
        bus(0, 8'h06, 16'h0086);
        short_ld <= 9'h000;
        wait_gate(6, 1300);
        bus(0, 8'h06, 16'h0085);
        bus(1, ADDR_GATE_MODE, 16'h0006);
        direct_on <= 9'h180;
        repeat (5) @(posedge clk);
        bus(0, ADDR_OUT_STATE, 16'h01C0);
        bus(1, ADDR_GATE_MODE, 16'h0002);
        repeat (5) @(posedge clk);
        final_report();
    end
endmodule
